// ==== design/twm_master.sv ====
// twm_master: single-master two-wire bus controller with byte DMA reader and writer
// assumes an APB master on sys_clk, open-drain pads outside and a byte-wide RAM port
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module twm_master
  import twm_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // event interconnect
  input  wire twm_task_s        task_in,
  output twm_event_s            event_out,
  // ram port
  output logic                  mem_req,
  output logic                  mem_we,
  output logic      [31:0]      mem_addr,
  output logic      [7:0]       mem_wdata,
  input  wire logic [7:0]       mem_rdata,
  input  wire logic             mem_ack,
  // bus pins, open drain
  input  wire logic             scl_in,
  output logic                  scl_out,
  output logic                  scl_oe,
  input  wire logic             sda_in,
  output logic                  sda_out,
  output logic                  sda_oe
);

  // software registers
  logic [31:0]       tx_ptr_reg;
  logic [31:0]       rx_ptr_reg;
  logic [CNT_W-1:0]  tx_max_reg;
  logic [CNT_W-1:0]  rx_max_reg;
  logic [6:0]        addr_reg;
  logic [1:0]        freq_reg;
  logic              enable_reg;
  logic [1:0]        shorts_reg;
  logic [TWM_NUM_EV-1:0] ev_flag_reg;

  // sequencer state
  twm_state_e        state_reg;
  logic [1:0]        phase_reg;
  logic [7:0]        qcnt_reg;
  logic [3:0]        bit_reg;
  logic [7:0]        shift_reg;
  logic              is_rx_reg;
  logic              addr_phase_reg;
  logic              nack_reg;
  logic [31:0]       ptr_act_reg;
  logic [CNT_W-1:0]  max_act_reg;
  logic [CNT_W-1:0]  cnt_reg;
  logic              stop_pend_reg;
  logic              susp_pend_reg;

  // combinational helpers
  logic [1:0]        pins_s;
  logic              scl_s;
  logic              sda_s;
  logic              apb_fire;
  logic              apb_wr;
  twm_task_s         tsk;
  logic [7:0]        qtr_sel;
  logic              stretch;
  logic              tick;
  logic              busy;
  logic              last_byte;
  logic              more;
  logic              rx_nack;
  logic [31:0]       rd_data;
  logic              rd_hit;

  // pins pass two flops before any logic sees them
  twm_sync #(.W(2)) u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in ({scl_in, sda_in}),
    .sync_out (pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // access phase completes on the second cycle with pready high
  assign apb_fire = psel && penable && pready;
  assign apb_wr   = apb_fire && pwrite;

  // tasks from interconnect, register writes and shortcuts
  always_comb begin
    tsk          = task_in;
    tsk.rx_begin = task_in.rx_begin | (apb_wr && paddr == TWM_OFF_TASK_RX && pwdata[0]);
    tsk.tx_begin = task_in.tx_begin | (apb_wr && paddr == TWM_OFF_TASK_TX && pwdata[0]);
    tsk.suspend  = task_in.suspend | (apb_wr && paddr == TWM_OFF_TASK_SUSP && pwdata[0]);
    tsk.resume   = task_in.resume | (apb_wr && paddr == TWM_OFF_TASK_RES && pwdata[0]);
    tsk.stop     = task_in.stop | (apb_wr && paddr == TWM_OFF_TASK_STOP && pwdata[0])
                 | (event_out.final_transmit_byte_event && shorts_reg[TWM_SHORT_FIN_TX_STOP])
                 | (event_out.final_receive_byte_event && shorts_reg[TWM_SHORT_FIN_RX_STOP]);
  end

  // quarter-bit length for the selected rate
  always_comb begin
    case (freq_reg)
      TWM_FREQ_250K: qtr_sel = 8'(TWM_QTR_250K);
      TWM_FREQ_400K: qtr_sel = 8'(TWM_QTR_400K);
      default:       qtr_sel = 8'(TWM_QTR_100K);
    endcase
  end

  // clock high phase does not run while a slave still holds scl low
  assign stretch = (phase_reg == 2'h1) && !scl_s;
  assign tick    = !stretch && (qcnt_reg == qtr_sel - 8'h01);
  assign busy    = (state_reg == TWM_START) || (state_reg == TWM_BYTE) || (state_reg == TWM_FETCH)
                || (state_reg == TWM_STORE) || (state_reg == TWM_NEXT);
  assign last_byte = (max_act_reg != '0) && (cnt_reg == max_act_reg - 1'b1);
  assign more      = cnt_reg < max_act_reg;
  // nack the final byte, or any byte once a stop is waiting
  assign rx_nack   = last_byte || stop_pend_reg;

  // apb configuration registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_ptr_reg <= TWM_RST_PTR;
      rx_ptr_reg <= TWM_RST_PTR;
      tx_max_reg <= '0;
      rx_max_reg <= '0;
      addr_reg   <= TWM_RST_ADDR;
      freq_reg   <= TWM_RST_FREQ;
      enable_reg <= 1'b0;
      shorts_reg <= TWM_RST_SHORTS;
    end else if (apb_wr) begin
      case (paddr)
        TWM_OFF_TX_PTR:  tx_ptr_reg <= pwdata;
        TWM_OFF_RX_PTR:  rx_ptr_reg <= pwdata;
        TWM_OFF_TX_MAX:  tx_max_reg <= pwdata[CNT_W-1:0];
        TWM_OFF_RX_MAX:  rx_max_reg <= pwdata[CNT_W-1:0];
        TWM_OFF_ADDRESS: addr_reg   <= pwdata[6:0];
        TWM_OFF_FREQ:    freq_reg   <= pwdata[1:0];
        TWM_OFF_ENABLE:  enable_reg <= pwdata[0];
        TWM_OFF_SHORTS:  shorts_reg <= pwdata[1:0];
        default:         ;
      endcase
    end
  end

  // sticky event flags; a new event wins over a clearing write
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ev_flag_reg <= '0;
    end else begin
      for (int i = 0; i < TWM_NUM_EV; i++) begin
        if (event_out[i]) begin
          ev_flag_reg[i] <= 1'b1;
        end else if (apb_wr && paddr == TWM_EV_OFFS[i] && !pwdata[0]) begin
          ev_flag_reg[i] <= 1'b0;
        end
      end
    end
  end

  // read multiplexer
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (paddr)
      TWM_OFF_TASK_RX, TWM_OFF_TASK_TX, TWM_OFF_TASK_STOP,
      TWM_OFF_TASK_SUSP, TWM_OFF_TASK_RES: rd_data = 32'h0000_0000;
      TWM_OFF_TX_PTR:  rd_data = tx_ptr_reg;
      TWM_OFF_RX_PTR:  rd_data = rx_ptr_reg;
      TWM_OFF_TX_MAX:  rd_data = 32'(tx_max_reg);
      TWM_OFF_RX_MAX:  rd_data = 32'(rx_max_reg);
      TWM_OFF_ADDRESS: rd_data = {25'h0000000, addr_reg};
      TWM_OFF_FREQ:    rd_data = {30'h00000000, freq_reg};
      TWM_OFF_ENABLE:  rd_data = {31'h00000000, enable_reg};
      TWM_OFF_SHORTS:  rd_data = {30'h00000000, shorts_reg};
      default: begin
        rd_hit = 1'b0;
        for (int i = 0; i < TWM_NUM_EV; i++) begin
          if (paddr == TWM_EV_OFFS[i]) begin
            rd_hit  = 1'b1;
            rd_data = {31'h00000000, ev_flag_reg[i]};
          end
        end
      end
    endcase
  end

  // apb answer: one wait state, error on unmapped address
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h0000_0000 : rd_data;
      pslverr <= !rd_hit;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // pending stop and suspend requests, taken at the next byte boundary
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stop_pend_reg <= 1'b0;
      susp_pend_reg <= 1'b0;
    end else begin
      if (state_reg == TWM_IDLE || state_reg == TWM_STOP) begin
        stop_pend_reg <= 1'b0;
      end else if (tsk.stop && state_reg != TWM_SUSP) begin
        stop_pend_reg <= 1'b1;
      end
      if (state_reg == TWM_SUSP || state_reg == TWM_IDLE) begin
        susp_pend_reg <= 1'b0;
      end else if (tsk.suspend && busy) begin
        susp_pend_reg <= 1'b1;
      end
    end
  end

  // bus sequencer, bit engine and dma
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg      <= TWM_IDLE;
      phase_reg      <= 2'h0;
      qcnt_reg       <= 8'h00;
      bit_reg        <= 4'h0;
      shift_reg      <= 8'h00;
      is_rx_reg      <= 1'b0;
      addr_phase_reg <= 1'b0;
      nack_reg       <= 1'b0;
      ptr_act_reg    <= TWM_RST_PTR;
      max_act_reg    <= '0;
      cnt_reg        <= '0;
      event_out      <= '0;
      mem_req        <= 1'b0;
      mem_we         <= 1'b0;
      mem_addr       <= 32'h0000_0000;
      mem_wdata      <= 8'h00;
      scl_out        <= 1'b0;
      scl_oe         <= 1'b0;
      sda_out        <= 1'b0;
      sda_oe         <= 1'b0;
    end else begin
      event_out <= '0;
      // quarter timer for the timed states
      if (state_reg == TWM_START || state_reg == TWM_BYTE || state_reg == TWM_STOP) begin
        if (stretch || tick) begin
          qcnt_reg <= 8'h00;
        end else begin
          qcnt_reg <= qcnt_reg + 8'h01;
        end
        if (tick) begin
          phase_reg <= phase_reg + 2'h1;
        end
      end
      case (state_reg)
        TWM_IDLE, TWM_HOLD: begin
          if (state_reg == TWM_IDLE) begin
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
          end
          if (enable_reg && (tsk.tx_begin || tsk.rx_begin)) begin
            // load the staged copies; software may refill them now
            is_rx_reg      <= tsk.rx_begin;
            ptr_act_reg    <= tsk.rx_begin ? rx_ptr_reg : tx_ptr_reg;
            max_act_reg    <= tsk.rx_begin ? rx_max_reg : tx_max_reg;
            shift_reg      <= {addr_reg, tsk.rx_begin ? TWM_DIR_READ : TWM_DIR_WRITE};
            cnt_reg        <= '0;
            addr_phase_reg <= 1'b1;
            nack_reg       <= 1'b0;
            phase_reg      <= 2'h0;
            qcnt_reg       <= 8'h00;
            sda_oe         <= 1'b0;
            event_out.rxbegan <= tsk.rx_begin;
            event_out.txbegan <= !tsk.rx_begin;
            state_reg      <= TWM_START;
          end else if (state_reg == TWM_HOLD && stop_pend_reg) begin
            phase_reg <= 2'h0;
            qcnt_reg  <= 8'h00;
            sda_oe    <= 1'b1;
            state_reg <= TWM_STOP;
          end else if (state_reg == TWM_IDLE && tsk.stop) begin
            event_out.stopped <= 1'b1;
          end
        end
        TWM_START: begin
          // sda released, scl released, sda falls, scl falls
          if (tick) begin
            case (phase_reg)
              2'h0: scl_oe <= 1'b0;
              2'h1: sda_oe <= 1'b1;
              2'h2: scl_oe <= 1'b1;
              default: begin
                bit_reg   <= 4'h8;
                sda_oe    <= !shift_reg[7];
                state_reg <= TWM_BYTE;
              end
            endcase
          end
        end
        TWM_BYTE: begin
          // bits 8..1 carry data, bit 0 is the acknowledge slot
          if (tick) begin
            case (phase_reg)
              2'h0: scl_oe <= 1'b0;
              2'h1: begin
                if (bit_reg != 4'h0) begin
                  shift_reg <= (is_rx_reg && !addr_phase_reg) ? {shift_reg[6:0], sda_s}
                                                              : {shift_reg[6:0], 1'b0};
                end else if (!is_rx_reg || addr_phase_reg) begin
                  nack_reg <= (sda_s == TWM_NACK);
                  event_out.error <= (sda_s == TWM_NACK);
                end
              end
              2'h2: scl_oe <= 1'b1;
              default: begin
                if (bit_reg != 4'h0) begin
                  bit_reg <= bit_reg - 4'h1;
                  if (bit_reg == 4'h1) begin
                    // master drives the slot only when receiving data
                    sda_oe <= is_rx_reg && !addr_phase_reg && !rx_nack;
                  end else if (is_rx_reg && !addr_phase_reg) begin
                    sda_oe <= 1'b0;
                  end else begin
                    sda_oe <= !shift_reg[7];
                  end
                end else begin
                  sda_oe <= 1'b0;
                  addr_phase_reg <= 1'b0;
                  if (!addr_phase_reg && is_rx_reg) begin
                    mem_req   <= 1'b1;
                    mem_we    <= 1'b1;
                    mem_addr  <= ptr_act_reg + 32'(cnt_reg);
                    mem_wdata <= shift_reg;
                    state_reg <= TWM_STORE;
                  end else begin
                    if (!addr_phase_reg) begin
                      cnt_reg <= cnt_reg + 1'b1;
                    end
                    state_reg <= nack_reg ? TWM_HOLD : TWM_NEXT;
                  end
                end
              end
            endcase
          end
        end
        TWM_STORE: begin
          if (mem_ack) begin
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            cnt_reg   <= cnt_reg + 1'b1;
            state_reg <= TWM_NEXT;
          end
        end
        TWM_NEXT: begin
          phase_reg <= 2'h0;
          qcnt_reg  <= 8'h00;
          if (stop_pend_reg) begin
            sda_oe    <= 1'b1;
            state_reg <= TWM_STOP;
          end else if (susp_pend_reg) begin
            event_out.suspended <= 1'b1;
            state_reg <= TWM_SUSP;
          end else if (!more) begin
            state_reg <= TWM_HOLD;
          end else if (is_rx_reg) begin
            event_out.final_receive_byte_event <= last_byte;
            bit_reg   <= 4'h8;
            sda_oe    <= 1'b0;
            state_reg <= TWM_BYTE;
          end else begin
            mem_req   <= 1'b1;
            mem_we    <= 1'b0;
            mem_addr  <= ptr_act_reg + 32'(cnt_reg);
            state_reg <= TWM_FETCH;
          end
        end
        TWM_FETCH: begin
          if (mem_ack) begin
            mem_req   <= 1'b0;
            shift_reg <= mem_rdata;
            event_out.final_transmit_byte_event <= last_byte;
            bit_reg   <= 4'h8;
            sda_oe    <= !mem_rdata[7];
            state_reg <= TWM_BYTE;
          end
        end
        TWM_SUSP: begin
          // scl stays low, stretching the bus until resumed
          scl_oe <= 1'b1;
          if (tsk.resume) begin
            state_reg <= TWM_NEXT;
          end
        end
        TWM_STOP: begin
          // sda low, scl released, sda released
          if (tick) begin
            case (phase_reg)
              2'h0: scl_oe <= 1'b0;
              2'h1: sda_oe <= 1'b0;
              2'h2: ;
              default: state_reg <= TWM_DONE;
            endcase
          end
        end
        TWM_DONE: begin
          if (!mem_req) begin
            event_out.stopped <= 1'b1;
            state_reg <= TWM_IDLE;
          end
        end
        default: state_reg <= TWM_IDLE;
      endcase
    end
  end

endmodule : twm_master
`default_nettype wire

// ==== design/twm_sync.sv ====
// twm_sync: two-stage synchroniser for a group of asynchronous levels
// assumes the inputs come from pins outside the sys_clk domain
`timescale 1ns/10ps
`default_nettype none
module twm_sync #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  // first stage feeds only the second; bus lines idle high
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_reg <= '1;
      sync_out <= '1;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : twm_sync
`default_nettype wire

// ==== pkg/twm_pkg.sv ====
// twm_pkg: constants, register map and carrier types of the two-wire bus master
// assumes a 25 MHz system clock and a 12-bit byte address on the register bus
package twm_pkg;

  // clock and bus rates
  localparam int TWM_CLK_HZ     = 25000000;
  localparam int TWM_RATE_100K  = 100000;
  localparam int TWM_RATE_250K  = 250000;
  localparam int TWM_RATE_400K  = 400000;
  // a bit is four quarter phases; a least time, so round up
  localparam int TWM_QTR_100K   = (TWM_CLK_HZ + 4 * TWM_RATE_100K - 1) / (4 * TWM_RATE_100K);
  localparam int TWM_QTR_250K   = (TWM_CLK_HZ + 4 * TWM_RATE_250K - 1) / (4 * TWM_RATE_250K);
  localparam int TWM_QTR_400K   = (TWM_CLK_HZ + 4 * TWM_RATE_400K - 1) / (4 * TWM_RATE_400K);

  // frequency selector codes
  localparam logic [1:0] TWM_FREQ_100K = 2'h0;
  localparam logic [1:0] TWM_FREQ_250K = 2'h1;
  localparam logic [1:0] TWM_FREQ_400K = 2'h2;

  // register offsets (byte addresses)
  localparam logic [11:0] TWM_OFF_TASK_RX   = 12'h000;
  localparam logic [11:0] TWM_OFF_TASK_TX   = 12'h008;
  localparam logic [11:0] TWM_OFF_TASK_STOP = 12'h014;
  localparam logic [11:0] TWM_OFF_TASK_SUSP = 12'h01c;
  localparam logic [11:0] TWM_OFF_TASK_RES  = 12'h020;
  localparam logic [11:0] TWM_OFF_EV_STOP   = 12'h104;
  localparam logic [11:0] TWM_OFF_EV_ERR    = 12'h124;
  localparam logic [11:0] TWM_OFF_EV_SUSP   = 12'h148;
  localparam logic [11:0] TWM_OFF_EV_RXBEG  = 12'h14c;
  localparam logic [11:0] TWM_OFF_EV_TXBEG  = 12'h150;
  localparam logic [11:0] TWM_OFF_EV_FIN_RX = 12'h15c;
  localparam logic [11:0] TWM_OFF_EV_FIN_TX = 12'h160;
  localparam logic [11:0] TWM_OFF_SHORTS    = 12'h200;
  localparam logic [11:0] TWM_OFF_ENABLE    = 12'h500;
  localparam logic [11:0] TWM_OFF_FREQ      = 12'h524;
  localparam logic [11:0] TWM_OFF_RX_PTR    = 12'h534;
  localparam logic [11:0] TWM_OFF_RX_MAX    = 12'h538;
  localparam logic [11:0] TWM_OFF_TX_PTR    = 12'h544;
  localparam logic [11:0] TWM_OFF_TX_MAX    = 12'h548;
  localparam logic [11:0] TWM_OFF_ADDRESS   = 12'h588;

  // shortcut field positions
  localparam int TWM_SHORT_FIN_TX_STOP = 0;
  localparam int TWM_SHORT_FIN_RX_STOP = 1;

  // reset values
  localparam logic [31:0] TWM_RST_PTR    = 32'h0000_0000;
  localparam logic [1:0]  TWM_RST_FREQ   = TWM_FREQ_100K;
  localparam logic [6:0]  TWM_RST_ADDR   = 7'h00;
  localparam logic [1:0]  TWM_RST_SHORTS = 2'h0;

  // direction bit after the address
  localparam logic TWM_DIR_WRITE = 1'b0;
  localparam logic TWM_DIR_READ  = 1'b1;
  // acknowledge slot levels
  localparam logic TWM_ACK  = 1'b0;
  localparam logic TWM_NACK = 1'b1;

  // tasks, one-cycle strobes
  typedef struct packed {
    logic rx_begin;
    logic tx_begin;
    logic stop;
    logic suspend;
    logic resume;
  } twm_task_s;

  // events, one-cycle pulses; order matches TWM_EV_OFFS
  typedef struct packed {
    logic final_transmit_byte_event;
    logic final_receive_byte_event;
    logic txbegan;
    logic rxbegan;
    logic suspended;
    logic error;
    logic stopped;
  } twm_event_s;

  localparam int TWM_NUM_EV = 7;
  localparam logic [TWM_NUM_EV-1:0][11:0] TWM_EV_OFFS = {
    TWM_OFF_EV_FIN_TX, TWM_OFF_EV_FIN_RX, TWM_OFF_EV_TXBEG, TWM_OFF_EV_RXBEG,
    TWM_OFF_EV_SUSP, TWM_OFF_EV_ERR, TWM_OFF_EV_STOP};

  // sequencer states
  typedef enum logic [3:0] {
    TWM_IDLE  = 4'h0,
    TWM_START = 4'h1,
    TWM_BYTE  = 4'h2,
    TWM_FETCH = 4'h3,
    TWM_STORE = 4'h4,
    TWM_NEXT  = 4'h5,
    TWM_HOLD  = 4'h6,
    TWM_SUSP  = 4'h7,
    TWM_STOP  = 4'h8,
    TWM_DONE  = 4'h9
  } twm_state_e;

endpackage : twm_pkg

// ==== tb/twm_master_bench.sv ====
// twm_master_bench: self-checking bench for twm_master
// assumes twm_slave on the wired-and lines and a byte ram here
`timescale 1ns/10ps
`default_nettype none
module twm_master_bench;
  import twm_pkg::*;
  logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, mem_req, mem_we, mem_ack;
  logic        scl_oe, sda_oe, s_scl, s_sda, nack, stretch, mack, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, mem_addr, rd, seed;
  logic [7:0]  mem_rdata, mem_wdata, rbyte, got;
  twm_task_s   task_in;
  twm_event_s  event_out;
  int          failures, checks_done, gotn;
  logic [7:0]  exp_q[$];
  wire         scl = !(scl_oe || s_scl);
  wire         sda = !(sda_oe || s_sda);
  twm_master i_dut (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .task_in, .event_out, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .scl_in(scl),
    .scl_out(), .scl_oe, .sda_in(sda), .sda_out(), .sda_oe);
  twm_slave i_slv (.scl, .sda, .nack, .stretch, .rbyte, .s_sda, .s_scl, .got, .gotn, .mack);
  // clock
  initial begin
    sys_clk = 0;
    forever #20 sys_clk = !sys_clk;
  end
  // xorshift step
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  // counted comparison
  task automatic chk(input logic [31:0] v, input logic [31:0] e);
    checks_done++;
    if (v !== e) begin
      failures++;
      $display("BAD at %0t got %h exp %h", $time, v, e);
    end
  endtask : chk
  // verdict
  task automatic final_report;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // bounded wait for event bit b; e says whether it should come
  task automatic wev(input int b, input int n, input logic e);
    int i;
    for (i = 0; i < n && event_out[b] !== 1'b1; i++) @(posedge sys_clk);
    chk(i < n, e);
    if (e && i >= n) final_report();
  endtask : wev
  // one apb transfer with an idle cycle after it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk) penable <= 1;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (i >= 50) begin
      failures++;
      final_report();
    end
    @(posedge sys_clk);
  endtask : apb
  // one-cycle task strobe
  task automatic go(input logic [4:0] t);
    task_in <= t;
    @(posedge sys_clk) task_in <= '0;
  endtask : go
  // program a sequence, note expected bytes, begin it
  task automatic seq(input logic r, input logic [1:0] f, input int n, input int m);
    seed = xs(seed);
    rbyte = seed[23:16];
    apb(1, TWM_OFF_ADDRESS, {25'h0, seed[14:8]});
    apb(1, TWM_OFF_FREQ, {30'h0, f});
    apb(1, r ? TWM_OFF_RX_MAX : TWM_OFF_TX_MAX, n);
    exp_q.push_back({seed[14:8], r});
    for (int i = 0; i < m; i++) exp_q.push_back(r ? rbyte + 8'(i + 1) : 8'(8'h40 + i) ^ seed[7:0]);
    go(r ? 5'h10 : 5'h08);
  endtask : seq
  // ram with one-cycle ack; byte writes checked against the queue
  always @(posedge sys_clk) begin
    mem_ack <= mem_req && !mem_ack;
    mem_rdata <= mem_addr[7:0] ^ seed[7:0];
    if (mem_req && mem_ack && mem_we) chk(mem_wdata, exp_q.pop_front());
  end
  // bytes seen by the slave checked against the queue
  always @(gotn) chk(got, exp_q.pop_front());
  // reset, then the scenarios
  initial begin
    {rst_n, psel, penable, pwrite, mem_ack, nack, stretch} = '0;
    {paddr, pwdata, mem_rdata, task_in, rbyte} = '0;
    seed = 32'd26511;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1;
    @(posedge sys_clk);
    apb(0, TWM_OFF_EV_STOP, 0);
    chk(rd, 0);
    apb(0, 12'h3f0, 0);
    chk(err, 1);
    go(5'h06);
    wev(0, 20, 1);
    apb(0, TWM_OFF_EV_SUSP, 0);
    chk(rd, 0);
    apb(1, TWM_OFF_ENABLE, 1);
    apb(1, TWM_OFF_SHORTS, 3);
    apb(1, TWM_OFF_TX_PTR, 32'h40);
    seq(0, TWM_FREQ_400K, 3, 3);
    wev(0, 20000, 1);
    apb(0, TWM_OFF_EV_FIN_TX, 0);
    chk(rd, 1);
    stretch <= 1;
    seq(1, TWM_FREQ_250K, 4, 4);
    wev(0, 20000, 1);
    chk(mack, 1);
    apb(0, TWM_OFF_EV_FIN_RX, 0);
    chk(rd, 1);
    stretch <= 0;
    nack <= 1;
    seq(0, TWM_FREQ_100K, 1, 0);
    wev(1, 10000, 1);
    wev(0, 3000, 0);
    nack <= 0;
    go(5'h04);
    wev(0, 3000, 1);
    seq(0, TWM_FREQ_100K, 3, 3);
    wev(4, 10, 1);
    apb(1, TWM_OFF_TX_MAX, 1);
    go(5'h02);
    wev(2, 5000, 1);
    repeat (500) @(posedge sys_clk);
    chk(scl, 0);
    go(5'h01);
    wev(0, 20000, 1);
    chk(exp_q.size(), 0);
    apb(1, TWM_OFF_ENABLE, 0);
    go(5'h08);
    wev(4, 20, 0);
    final_report();
  end
endmodule : twm_master_bench
`default_nettype wire

// ==== tb/twm_master_properties.sv ====
// checker: port-level properties of twm_master
// assumes it is bound onto twm_master
`timescale 1ns/10ps
`default_nettype none
module twm_master_properties
  import twm_pkg::*;
(
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_n,
  // observed ports
  input wire twm_task_s  task_in,
  input wire twm_event_s event_out,
  input wire logic       mem_req,
  input wire logic       mem_ack,
  input wire logic       scl_in,
  input wire logic       scl_out,
  input wire logic       scl_oe,
  input wire logic       sda_out,
  input wire logic       sda_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic busy_reg;
  // a sequence runs from began to stopped
  always_ff @(posedge sys_clk) begin
    if (!rst_n) busy_reg <= 1'b0;
    else if (event_out.txbegan || event_out.rxbegan) busy_reg <= 1'b1;
    else if (event_out.stopped) busy_reg <= 1'b0;
  end
  property p_od; !scl_out && !sda_out; endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  property p_start; event_out.txbegan || event_out.rxbegan |-> ##[1:300] (sda_oe && !scl_oe); endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_susp; event_out.suspended |-> ##[0:2] scl_oe [*4]; endproperty
  a_susp: assert property (p_susp) else $error("clock not held");
  property p_idle; !busy_reg && task_in.suspend |=> (!event_out.suspended) [*8]; endproperty
  a_idle: assert property (p_idle) else $error("idle suspend taken");
  property p_stop_mem; event_out.stopped |-> !mem_req; endproperty
  a_stop_mem: assert property (p_stop_mem) else $error("ram busy at stop");
  property p_stop_rel; event_out.stopped |-> !scl_oe && !sda_oe; endproperty
  a_stop_rel: assert property (p_stop_rel) else $error("lines held at stop");
  property p_fin_tx; event_out.final_transmit_byte_event |-> $past(mem_ack) || $past(mem_ack, 2); endproperty
  a_fin_tx: assert property (p_fin_tx) else $error("last byte early");
  property p_stretch; (!scl_oe && !scl_in) [*3] |=> !scl_oe; endproperty
  a_stretch: assert property (p_stretch) else $error("stretch ignored");
  c_fin_rx: cover property (event_out.final_receive_byte_event);
  c_error: cover property (event_out.error);
  c_susp: cover property (event_out.suspended);
endmodule : twm_master_properties
bind twm_master twm_master_properties i_props (.sys_clk, .rst_n, .task_in, .event_out, .mem_req, .mem_ack,
  .scl_in, .scl_out, .scl_oe, .sda_out, .sda_oe);
`default_nettype wire

// ==== tb/twm_slave.sv ====
// twm_slave: behavioural slave on the wired-and lines
// assumes pull-ups; acks unless nack is set
`timescale 1ns/10ps
`default_nettype none
module twm_slave (
  // lines
  input  wire logic       scl,
  input  wire logic       sda,
  // behaviour
  input  wire logic       nack,
  input  wire logic       stretch,
  input  wire logic [7:0] rbyte,
  // drives and observations
  output logic            s_sda = 0,
  output logic            s_scl = 0,
  output logic [7:0]      got,
  output int              gotn = 0,
  output logic            mack
);
  int         n = 0;
  logic       rd = 0;
  logic       adr = 0;
  logic [7:0] sh, k, b;
  // start condition opens an address byte
  always @(negedge sda) if (scl) begin
    n = 0;
    adr = 1;
    k = 0;
  end
  // rising clock samples; ninth bit is the ack slot
  always @(posedge scl) begin
    if (n == 8) begin
      if (rd && !adr) begin
        mack = sda;
        rd = !sda;
      end
      k = k + 8'h01;
      adr = 0;
      n = 0;
    end else begin
      sh = {sh[6:0], sda};
      n++;
      if (n == 8 && (adr || !rd)) begin
        got = sh;
        gotn++;
        if (adr) rd = sh[0];
      end
    end
  end
  // falling clock: ack, read data or release, then optional stretch
  // the stretch outlasts the master's own low half so its wait is really exercised
  always @(negedge scl) begin
    b = rbyte + k;
    if (n == 8) s_sda = (adr || !rd) && !nack;
    else s_sda = rd && !adr && !b[7-n];
    if (stretch) begin
      s_scl = 1;
      #3000 s_scl = 0;
    end
  end
endmodule : twm_slave
`default_nettype wire
